/* File: enable_sync_powergood_ctrl.sv */
// regulator control: enable decode, sync lock, output-good flag
`timescale 1ns/100ps
module enable_sync_powergood_ctrl
    import regctl_pkg::*;
#(
    parameter int unsigned RELEASE_CYCLES = RELEASE_CYC,
    parameter int unsigned SOFTSTART_CYCLES = SS_CYC,
    parameter int unsigned LOCK_COUNT = LOCK_PULSES
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    regctl_if.device link,
    input wire logic vin_ok,
    input wire logic freq_set_ok,
    input wire logic fb_in_window,
    input wire logic current_limit,
    input wire logic thermal_sd,
    input wire logic output_full,
    input wire logic ton_toff_limit,
    output logic [1:0] mode,
    output logic switch_node_en,
    output logic spread_en,
    output logic sync_locked,
    output logic freq_fold,
    output logic [15:0] sync_period,
    output logic [5:0] phase_adj
);
    import regctl_pkg::*;

    pwr_state_t pst_r, pst_nxt;
    lock_state_t lst_r, lst_nxt;
    logic en_r, en_nxt, sync_d_r, pull_r, pull_nxt;
    logic [15:0] blank_r, blank_nxt, hi_r, hi_nxt, lo_r, lo_nxt;
    logic [15:0] per_r, per_nxt, pcnt_r, pcnt_nxt;
    logic [11:0] lcnt_r, lcnt_nxt;
    logic [5:0] ph_r, ph_nxt;
    logic [23:0] filt_r, filt_nxt, rel_r, rel_nxt, ss_r, ss_nxt;
    logic [1:0] mode_nxt;
    logic switch_nxt, spr_nxt, lock_nxt, fold_nxt, rise, fall, pulse_ok;

    assign rise = link.sync_pulse && !sync_d_r;
    assign fall = !link.sync_pulse && sync_d_r;
    // both widths above edge minimum, under blanking
    assign pulse_ok = (hi_r >= 16'(EDGE_CYC)) && (hi_r < 16'(BLANK_CYC)) &&
        (lo_r >= 16'(EDGE_CYC)) && (lo_r < 16'(BLANK_CYC));

    always_comb begin
        en_nxt = en_r;
        blank_nxt = (blank_r != 16'h0000) ? blank_r - 16'h0001 : 16'h0000;
        if (pst_r == ST_SHUT) begin
            en_nxt = link.en_level;
            blank_nxt = 16'h0000;
        end else if (rise || fall) begin
            blank_nxt = 16'(BLANK_CYC);
        end else if (blank_r == 16'h0000) begin
            en_nxt = link.en_level;
        end
        pst_nxt = ST_SHUT;
        if (link.en_wake && freq_set_ok) begin
            pst_nxt = (en_nxt && vin_ok) ? ST_RUN : ST_STBY;
        end
        mode_nxt = MODE_OFF;
        if (pst_nxt == ST_STBY) begin
            mode_nxt = MODE_STANDBY;
        end else if (pst_nxt == ST_RUN) begin
            mode_nxt = MODE_RUN;
        end
        switch_nxt = pst_nxt == ST_RUN;
        fold_nxt = (pst_nxt == ST_RUN) && ton_toff_limit;
    end

    always_comb begin
        // widths kept until the next edge of the same kind
        hi_nxt = rise ? 16'h0001 : hi_r + {15'h0000, link.sync_pulse};
        lo_nxt = fall ? 16'h0001 : lo_r + {15'h0000, !link.sync_pulse};
        if (hi_r == 16'hffff && !rise) hi_nxt = hi_r;
        if (lo_r == 16'hffff && !fall) lo_nxt = lo_r;
        pcnt_nxt = rise ? 16'h0001 : pcnt_r + 16'h0001;
        if (pcnt_r == 16'hffff && !rise) pcnt_nxt = pcnt_r;
        per_nxt = per_r;
        lst_nxt = lst_r;
        lcnt_nxt = lcnt_r;
        ph_nxt = ph_r;
        if (pst_r != ST_RUN || pcnt_r > 16'(PER_MAX_CYC)) begin
            lst_nxt = LK_FREE;
            lcnt_nxt = 12'h000;
            ph_nxt = 6'h00;
        end else if (rise) begin
            // period and width window at each rising edge
            if (!pulse_ok || pcnt_r < 16'(PER_MIN_CYC)) begin
                lst_nxt = LK_FREE;
                lcnt_nxt = 12'h000;
                ph_nxt = 6'h00;
            end else begin
                unique case (lst_r)
                    LK_FREE: begin
                        lst_nxt = LK_COUNT;
                        lcnt_nxt = 12'h001;
                    end
                    LK_COUNT: begin
                        lcnt_nxt = lcnt_r + 12'h001;
                        if (lcnt_r >= 12'(LOCK_COUNT - 1)) begin
                            lst_nxt = LK_PHASE;
                            // old cycle ends, new period starts
                            per_nxt = pcnt_r;
                            ph_nxt = 6'h00;
                        end
                    end
                    LK_PHASE: begin
                        per_nxt = pcnt_r;
                        ph_nxt = ph_r + 6'h01;
                        if (ph_r == 6'(PHASE_STEPS - 1)) lst_nxt = LK_LOCKED;
                    end
                    LK_LOCKED: per_nxt = pcnt_r;
                endcase
            end
        end
        lock_nxt = lst_nxt == LK_PHASE || lst_nxt == LK_LOCKED;
        spr_nxt = (pst_nxt == ST_RUN) && (lst_nxt == LK_FREE) &&
            !fold_nxt;
    end

    always_comb begin
        filt_nxt = 24'h000000;
        rel_nxt = 24'h000000;
        ss_nxt = ss_r;
        pull_nxt = 1'b1;
        if (pst_nxt != ST_RUN) begin
            ss_nxt = 24'h000000;
        end else begin
            if (!output_full && ss_r < 24'(SOFTSTART_CYCLES)) begin
                ss_nxt = ss_r + 24'h000001;
            end else begin
                ss_nxt = 24'(SOFTSTART_CYCLES);
            end
            if (!fb_in_window) begin
                filt_nxt = (filt_r < 24'(FILT_CYC)) ? filt_r + 24'h000001
                    : filt_r;
            end
            if (current_limit || thermal_sd || ss_nxt != 24'(SOFTSTART_CYCLES)
                || filt_nxt >= 24'(FILT_CYC) || (pull_r && !fb_in_window))
                begin
                rel_nxt = 24'h000000;
            end else if (pull_r) begin
                rel_nxt = rel_r + 24'h000001;
            end
            pull_nxt = pull_r ? (rel_nxt < 24'(RELEASE_CYCLES))
                : (current_limit || thermal_sd || filt_nxt >= 24'(FILT_CYC));
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pst_r <= ST_SHUT;
            lst_r <= LK_FREE;
            en_r <= 1'b0;
            sync_d_r <= 1'b0;
            pull_r <= 1'b1;
            blank_r <= 16'h0000;
            hi_r <= 16'h0000;
            lo_r <= 16'h0000;
            per_r <= 16'h0000;
            pcnt_r <= 16'h0000;
            lcnt_r <= 12'h000;
            ph_r <= 6'h00;
            filt_r <= 24'h000000;
            rel_r <= 24'h000000;
            ss_r <= 24'h000000;
            mode <= MODE_OFF;
            switch_node_en <= 1'b0;
            spread_en <= 1'b0;
            sync_locked <= 1'b0;
            freq_fold <= 1'b0;
            sync_period <= 16'h0000;
            phase_adj <= 6'h00;
        end else begin
            pst_r <= pst_nxt;
            lst_r <= lst_nxt;
            en_r <= en_nxt;
            sync_d_r <= link.sync_pulse;
            pull_r <= pull_nxt;
            blank_r <= blank_nxt;
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            per_r <= per_nxt;
            pcnt_r <= pcnt_nxt;
            lcnt_r <= lcnt_nxt;
            ph_r <= ph_nxt;
            filt_r <= filt_nxt;
            rel_r <= rel_nxt;
            ss_r <= ss_nxt;
            mode <= mode_nxt;
            switch_node_en <= switch_nxt;
            spread_en <= spr_nxt;
            sync_locked <= lock_nxt;
            freq_fold <= fold_nxt;
            sync_period <= per_nxt;
            phase_adj <= ph_nxt;
        end
    end

    assign link.good_pull_low = pull_r;
endmodule : enable_sync_powergood_ctrl

/* File: regctl_pkg.sv */
// shared constants and types for the enable/sync and output-good control
// Functional notes
// - below wake level stay in shutdown
// - wake but not enabled: supply on, no switching
// - enabled and supply ok: switch normally
// - after sync edge ignore enable change, blanking
// - no blanking while in shutdown
// - controller holds low beyond max blanking to disable
// - sync accepted only inside frequency range
// - controller keeps sync off until start-up done
// - sync pulse valid: edge widths within limits
// - after 2048 valid pulses adopt sync frequency
// - valid sync turns spread spectrum off
// - frequency step keeps phase, intermediate cycle
// - phase pulls in over tens of cycles
// - free run at pin-set frequency otherwise
// - frequency pin out of range forces shutdown
// - fold frequency back when on/off time limits
// - flag low when feedback outside good window
// - flag low in limit, thermal, disabled, start-up
// - excursions shorter than filter time ignored
// - enable low forces flag low at once
// - flag valid with enable low while supply ok
// - release delay before flag goes high
// - flag low through soft start
package regctl_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned BLANK_MIN_NS = 4_000;
    localparam int unsigned BLANK_MAX_NS = 28_000;
    localparam int unsigned EDGE_MIN_NS = 100;
    localparam int unsigned FILT_NS = 120_000;
    localparam int unsigned RELEASE_US = 2_000;
    localparam int unsigned SYNC_FMIN_HZ = 200_000;
    localparam int unsigned SYNC_FMAX_HZ = 2_200_000;
    localparam int unsigned LOCK_PULSES = 2048;
    localparam int unsigned PHASE_STEPS = 32;
    localparam int unsigned SS_CYC = 100_000;
    // blanking chosen mid-range: 16 us
    localparam int unsigned BLANK_CYC = (BLANK_MIN_NS + BLANK_MAX_NS) / 2
        * (CLK_HZ / 1_000_000) / 1000;
    localparam int unsigned EDGE_CYC = (EDGE_MIN_NS * (CLK_HZ / 1_000_000)
        + 999) / 1000;
    localparam int unsigned FILT_CYC = FILT_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam int unsigned RELEASE_CYC = RELEASE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PER_MIN_CYC = CLK_HZ / SYNC_FMAX_HZ;
    localparam int unsigned PER_MAX_CYC = CLK_HZ / SYNC_FMIN_HZ;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_STANDBY = 2'h1;
    localparam logic [1:0] MODE_RUN = 2'h2;
    typedef enum logic [1:0] {ST_SHUT, ST_STBY, ST_RUN} pwr_state_t;
    typedef enum logic [1:0] {LK_FREE, LK_COUNT, LK_PHASE, LK_LOCKED}
        lock_state_t;
endpackage : regctl_pkg

/* File: regctl_if.sv */
// link between regulator control and system controller
`timescale 1ns/100ps
interface regctl_if;
    logic en_wake;
    logic en_level;
    logic sync_pulse;
    logic good_pull_low;
    modport device (input en_wake, input en_level, input sync_pulse,
        output good_pull_low);
    modport host (output en_wake, output en_level, output sync_pulse,
        input good_pull_low);
endinterface : regctl_if

/* File: regctl_host.sv */
// system controller end: drives enable and sync, reads output-good
`timescale 1ns/100ps
module regctl_host
    import regctl_pkg::*;
#(
    parameter int unsigned DISABLE_CYC = BLANK_MAX_NS * (CLK_HZ / 1_000_000)
        / 1000 + 2
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    regctl_if.host link,
    input wire logic power_on,
    input wire logic sync_req,
    input wire logic [15:0] sync_half,
    output logic output_good,
    output logic disabled
);
    import regctl_pkg::*;

    logic en_r, en_nxt, syn_r, syn_nxt, good_r, wake_r, wake_nxt, dis_nxt;
    logic [15:0] hc_r, hc_nxt, half;
    logic [15:0] off_r, off_nxt;

    // clamp half period into the legal range
    always_comb begin
        half = sync_half;
        if (half < 16'(PER_MIN_CYC / 2 + 1)) half = 16'(PER_MIN_CYC / 2 + 1);
        if (half > 16'(PER_MAX_CYC / 2)) half = 16'(PER_MAX_CYC / 2);
    end

    always_comb begin
        en_nxt = power_on;
        syn_nxt = 1'b0;
        hc_nxt = 16'h0000;
        off_nxt = 16'h0000;
        dis_nxt = 1'b0;
        if (!power_on) begin
            // hold low past the longest blanking
            off_nxt = (off_r < 16'(DISABLE_CYC)) ? off_r + 16'h0001 : off_r;
            dis_nxt = off_r >= 16'(DISABLE_CYC);
        end else if (sync_req && good_r) begin
            hc_nxt = hc_r + 16'h0001;
            syn_nxt = syn_r;
            if (hc_r + 16'h0001 >= half) begin
                hc_nxt = 16'h0000;
                syn_nxt = !syn_r;
            end
        end
        // wake stays up until the disable hold has run out
        wake_nxt = power_on || (wake_r && !dis_nxt);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_r <= 1'b0;
            syn_r <= 1'b0;
            hc_r <= 16'h0000;
            off_r <= 16'h0000;
            good_r <= 1'b0;
            wake_r <= 1'b0;
            output_good <= 1'b0;
            disabled <= 1'b0;
        end else begin
            en_r <= en_nxt;
            syn_r <= syn_nxt;
            hc_r <= hc_nxt;
            off_r <= off_nxt;
            good_r <= !link.good_pull_low;
            wake_r <= wake_nxt;
            output_good <= !link.good_pull_low;
            disabled <= dis_nxt;
        end
    end

    assign link.en_wake = wake_r;
    assign link.en_level = en_r;
    assign link.sync_pulse = syn_r;
endmodule : regctl_host

/* File: regctl_properties.sv */
// assertions over the regulator control link and device outputs
`timescale 1ns/100ps
module regctl_properties
    import regctl_pkg::*;
#(
    parameter int unsigned RELEASE_CYCLES = RELEASE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic en_wake,
    input wire logic en_level,
    input wire logic sync_pulse,
    input wire logic good_pull_low,
    input wire logic vin_ok,
    input wire logic freq_set_ok,
    input wire logic fb_in_window,
    input wire logic [1:0] mode,
    input wire logic switch_node_en,
    input wire logic spread_en,
    input wire logic sync_locked
);
    logic [9:0] quiet_r, quiet_nxt;
    logic [15:0] win_r, win_nxt;
    logic sync_r;
    logic calm;
    // cycles since last sync edge, and in-window run length
    always_comb begin
        quiet_nxt = quiet_r + {9'h0, ~&quiet_r};
        if (sync_pulse != sync_r) begin
            quiet_nxt = 10'h0;
        end
        win_nxt = fb_in_window ? win_r + {15'h0, ~&win_r} : 16'h0;
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            quiet_r <= 10'h3ff;
            win_r <= 16'h0;
            sync_r <= 1'b0;
        end else begin
            quiet_r <= quiet_nxt;
            win_r <= win_nxt;
            sync_r <= sync_pulse;
        end
    end
    assign calm = quiet_r > 10'h191;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_off_below_wake: assert property (calm && !en_wake && $past(!en_wake)
        |-> ##[1:2] mode == MODE_OFF) else $error("mode not off");
    a_standby_no_switch: assert property (calm && en_wake && !en_level
        && freq_set_ok && $past(en_wake && !en_level && freq_set_ok)
        |-> ##[1:2] (mode == MODE_STANDBY && !switch_node_en))
        else $error("standby wrong");
    a_run_when_enabled: assert property (calm && en_wake && en_level
        && vin_ok && freq_set_ok
        && $past(en_wake && en_level && vin_ok && freq_set_ok)
        |-> ##[1:2] mode == MODE_RUN) else $error("not running");
    a_freq_fault_off: assert property (!freq_set_ok
        && $past(!freq_set_ok) |-> ##[1:2] mode == MODE_OFF)
        else $error("bad frequency pin not off");
    a_idle_no_switch: assert property (mode != MODE_RUN
        |-> !switch_node_en) else $error("switching while idle");
    a_idle_flag_low: assert property (mode != MODE_RUN
        |-> good_pull_low) else $error("flag high while idle");
    a_release_wait: assert property ($fell(good_pull_low)
        |-> win_r >= RELEASE_CYCLES - 1) else $error("released early");
    a_sync_no_spread: assert property (sync_locked |-> !spread_en)
        else $error("spread on while locked");
    a_lock_needs_sync: assert property ($rose(sync_locked) |-> !calm)
        else $error("lock without sync");
endmodule : regctl_properties

/* File: test_enable_sync_powergood_ctrl.sv */
// self-checking bench for both ends of the regulator control link
`timescale 1ns/100ps
module test_enable_sync_powergood_ctrl;
    import regctl_pkg::*;
    localparam int unsigned REL = 20;
    logic sys_clk, rst_b, vin_ok, freq_set_ok, fb_in_window, current_limit;
    logic thermal_sd, output_full, ton_toff_limit, power_on, sync_req;
    logic [15:0] sync_half, sync_period;
    logic [15:0] halves[3];
    logic [1:0] mode;
    logic [5:0] phase_adj;
    logic switch_node_en, spread_en, sync_locked, freq_fold;
    logic output_good, disabled;
    int errors, total_checks, cycles;
    regctl_if link ();
    enable_sync_powergood_ctrl #(.RELEASE_CYCLES(REL),
        .SOFTSTART_CYCLES(10), .LOCK_COUNT(4)) enable_sync_powergood_ctrl_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .link(link), .vin_ok(vin_ok),
        .freq_set_ok(freq_set_ok), .fb_in_window(fb_in_window),
        .current_limit(current_limit), .thermal_sd(thermal_sd),
        .output_full(output_full), .ton_toff_limit(ton_toff_limit),
        .mode(mode), .switch_node_en(switch_node_en), .spread_en(spread_en),
        .sync_locked(sync_locked), .freq_fold(freq_fold),
        .sync_period(sync_period), .phase_adj(phase_adj));
    regctl_host regctl_host_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .link(link), .power_on(power_on), .sync_req(sync_req),
        .sync_half(sync_half), .output_good(output_good),
        .disabled(disabled));
    regctl_properties #(.RELEASE_CYCLES(REL)) regctl_properties_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .en_wake(link.en_wake),
        .en_level(link.en_level), .sync_pulse(link.sync_pulse),
        .good_pull_low(link.good_pull_low), .vin_ok(vin_ok),
        .freq_set_ok(freq_set_ok), .fb_in_window(fb_in_window),
        .mode(mode), .switch_node_en(switch_node_en),
        .spread_en(spread_en), .sync_locked(sync_locked));
    task automatic check(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_cyc
    function automatic logic [15:0] exp_period(input logic [15:0] half);
        return half << 1;
    endfunction : exp_period
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        {vin_ok, freq_set_ok, fb_in_window, current_limit} = 4'h0;
        {thermal_sd, output_full, ton_toff_limit, power_on} = 4'h0;
        {rst_b, sync_req, errors, total_checks, cycles} = '0;
        sync_half = 16'h6;
        void'($urandom(23));
        halves = '{16'h6, 16'h3e, 16'($urandom_range(62, 6))};
        wait_cyc(2);
        rst_b = 1'b1;
        check("mode", mode, MODE_OFF);
        check("good_pull_low", link.good_pull_low, 16'h1);
        {power_on, vin_ok, freq_set_ok} = 3'h7;
        wait_cyc(8);
        check("mode", mode, MODE_RUN);
        check("switch_node_en", switch_node_en, 16'h1);
        {output_full, fb_in_window} = 2'h3;
        wait_cyc(10 + REL + 20);
        check("output_good", output_good, 16'h1);
        fb_in_window = 1'b0;
        wait_cyc($urandom_range(2000, 1));
        fb_in_window = 1'b1;
        wait_cyc(2);
        check("good_pull_low", link.good_pull_low, 16'h0);
        fb_in_window = 1'b0;
        wait_cyc(FILT_CYC + 20);
        check("good_pull_low", link.good_pull_low, 16'h1);
        fb_in_window = 1'b1;
        wait_cyc(REL + 20);
        check("output_good", output_good, 16'h1);
        ton_toff_limit = 1'b1;
        wait_cyc(4);
        check("freq_fold", freq_fold, 16'h1);
        ton_toff_limit = 1'b0;
        wait_cyc(4);
        check("spread_en", spread_en, 16'h1);
        foreach (halves[i]) begin
            sync_half = halves[i];
            sync_req = 1'b1;
            wait_cyc(45 * exp_period(sync_half));
            check("sync_locked", sync_locked, 16'h1);
            check("spread_en", spread_en, 16'h0);
            check("sync_period", sync_period, exp_period(sync_half));
            check("phase_adj", phase_adj, 16'h20);
            check("mode", mode, MODE_RUN);
            if (i == 2) begin
                // enable drops mid-sync: held by blanking, then standby
                power_on = 1'b0;
                wait_cyc(100);
                check("mode", mode, MODE_RUN);
                wait_cyc(400);
                check("mode", mode, MODE_STANDBY);
                check("switch_node_en", switch_node_en, 16'h0);
                check("good_pull_low", link.good_pull_low, 16'h1);
                check("disabled", disabled, 16'h0);
                power_on = 1'b1;
            end
            sync_req = 1'b0;
            wait_cyc(500);
            check("sync_locked", sync_locked, 16'h0);
            check("output_good", output_good, 16'h1);
        end
        current_limit = 1'b1;
        wait_cyc(4);
        check("good_pull_low", link.good_pull_low, 16'h1);
        current_limit = 1'b0;
        wait_cyc(REL + 20);
        check("output_good", output_good, 16'h1);
        thermal_sd = 1'b1;
        wait_cyc(FILT_CYC + 20);
        check("good_pull_low", link.good_pull_low, 16'h1);
        thermal_sd = 1'b0;
        freq_set_ok = 1'b0;
        wait_cyc(4);
        check("mode", mode, MODE_OFF);
        freq_set_ok = 1'b1;
        vin_ok = 1'b0;
        wait_cyc(4);
        check("mode", mode, MODE_STANDBY);
        vin_ok = 1'b1;
        wait_cyc(4);
        power_on = 1'b0;
        wait_cyc(720);
        check("disabled", disabled, 16'h1);
        check("mode", mode, MODE_OFF);
        check("switch_node_en", switch_node_en, 16'h0);
        check("good_pull_low", link.good_pull_low, 16'h1);
        conclude();
    end
endmodule : test_enable_sync_powergood_ctrl
